// file: dv/ssrs_spi_master.sv
`timescale 1ns/10ps
module ssrs_spi_master (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_mosi = 1'h0;
  end
  // The clock stands low between frames; data idles at the inverse of the last bit sent.
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    o_cs_n = 1'h0;
    #150;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = tx[i];
      #62.5 o_sclk = 1'h1;
      rx[i] = i_miso;
      #62.5 o_sclk = 1'h0;
    end
    o_mosi = ~o_mosi;
    #150 o_cs_n = 1'h1;
    #300;
  endtask : xfer
endmodule : ssrs_spi_master

// file: dv/ssrs_status_readback_bench.sv
`timescale 1ns/10ps
module ssrs_status_readback_bench;
  import ssrs_pkg::*;
  logic i_clk_sys = 1'h0, i_rst = 1'h1, i_ce = 1'h1;
  logic i_sclk, i_cs_n, i_si, o_so, o_so_oe_n, o_fault_status_pin;
  logic o_cmd_valid;
  logic [7:0] o_fault_flags, o_cmd_byte;
  logic [3:0] o_readback_select;
  logic i_in_pin = 1'h0, i_failsafe_input_pin = 1'h1, i_wake_pin = 1'h1;
  logic i_over_temperature = 1'h0, i_overcurrent_high = 1'h0;
  logic i_overcurrent_low = 1'h0, i_open_load = 1'h0;
  logic i_undervoltage = 1'h0, i_overvoltage = 1'h0;
  logic i_uv_latched_mode = 1'h1, i_spi_switch_on = 1'h0;
  logic i_current_sense_disable_bit = 1'h1, i_spi_switch_bit = 1'h0;
  logic i_oc_high_level = 1'h1, i_oc_timeout_dis = 1'h1;
  logic i_open_load_dis = 1'h0, i_failsafe_output_state = 1'h1;
  logic i_watchdog_timed_out = 1'h1, i_uv_protect_dis = 1'h0;
  logic i_ov_protect_dis = 1'h1;
  logic [2:0] i_oc_low_level = 3'h5, i_switching_delay_register = 3'h6;
  logic [1:0] i_oc_blank_time = 2'h1, i_watchdog_period_register = 2'h2;
  logic [3:0] i_direct_input_control_register = 4'hA;
  logic [15:0] rx;
  int mismatches = 0;
  int comparisons = 0;
  // Entry i is read in frame i while frame i selects entry i + 1.
  localparam logic [7:0] EXP [12] = '{8'h70, 8'h00, 8'h92, 8'h2D, 8'h35,
    8'h4A, 8'h5E, 8'hD6, 8'h63, 8'hE1, 8'hF0, 8'h00};
  ssrs_status_readback i_dut (.*);
  ssrs_spi_master i_master (
    .o_sclk(i_sclk),
    .o_cs_n(i_cs_n),
    .o_mosi(i_si),
    .i_miso(o_so)
  );
  always #10 i_clk_sys = ~i_clk_sys;
  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic pulse(input logic [6:0] v);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk_sys);
      {i_spi_switch_on, i_uv_latched_mode, i_over_temperature,
       i_overcurrent_high, i_overcurrent_low, i_open_load,
       i_undervoltage} <= (k == 0) ? v : {1'h0, v[5], 5'h00};
    end
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : pulse
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    repeat (5) @(posedge i_clk_sys);
    // Select edges then fall between system edges, away from the sampling.
    @(negedge i_clk_sys);
    for (int i = 0; i < 11; i++) begin
      i_master.xfer({8'h00, EXP[i + 1][7], ADDR_STATUS_SELECT,
                     EXP[i + 1][6:4]}, 8, rx);
      check("top", rx[7:4], EXP[i][7:4]);
      check("b32", rx[3:2], EXP[i][3:2]);
      check("b10", rx[1:0], EXP[i][1:0]);
    end
    pulse(7'h3F);
    check("flags", o_fault_flags, 8'h35);
    check("pin", o_fault_status_pin, 1'h1);
    i_master.xfer(16'h0000, 8, rx);
    check("read", rx, 16'h0035);
    check("clear", o_fault_flags, 8'h00);
    pulse(7'h01);
    check("live", o_fault_flags, 8'h01);
    pulse(7'h40);
    check("pin", o_fault_status_pin, 1'h0);
    i_master.xfer(16'h0011, 7, rx);
    i_master.xfer(16'hA500, 16, rx);
    check("chain", rx, 16'h01A5);
    pulse(7'h04);
    check("pin", o_fault_status_pin, 1'h1);
    @(posedge i_clk_sys);
    i_in_pin <= 1'h1;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("pin_in", o_fault_status_pin, 1'h0);
    stop_test();
  end
endmodule : ssrs_status_readback_bench

// file: dv/ssrs_status_readback_props.sv
`timescale 1ns/10ps
module ssrs_status_readback_props (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_in_pin,
  input wire logic i_over_temperature,
  input wire logic i_spi_switch_on,
  input wire logic o_so_oe_n,
  input wire logic o_fault_status_pin,
  input wire logic [ssrs_pkg::FRAME_BITS-1:0] o_fault_flags,
  input wire logic [3:0] o_readback_select,
  input wire logic o_cmd_valid,
  input wire logic [ssrs_pkg::FRAME_BITS-1:0] o_cmd_byte
);
  import ssrs_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_oe; o_so_oe_n == i_cs_n; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_sel0; $fell(i_rst) |-> o_readback_select == SELECT_RESET;
  endproperty
  a_sel0: assert property (p_sel0) else $error("sel0");
  // The summary flag is a register of its own and shows one cycle later.
  property p_ot; i_over_temperature |=> o_fault_flags[6] ##1 o_fault_flags[0];
  endproperty
  a_ot: assert property (p_ot) else $error("ot");
  // The pin input passes a synchroniser, so a quiet stretch is required.
  property p_hold; (!i_in_pin)[*6] ##0 (o_fault_status_pin &&
    !i_spi_switch_on) |=> o_fault_status_pin; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  // The cleared flags reach the output word one cycle after the frame's
  // valid pulse, while the selection has already moved on.
  property p_clr; $fell(o_fault_flags[5]) || $fell(o_fault_flags[4]) ||
    $fell(o_fault_flags[0]) |-> $past(o_cmd_valid) &&
    $past(o_readback_select[2:0], 2) == 3'h0; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_keep; !o_cmd_valid |-> $stable(o_readback_select);
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_cmd; o_cmd_valid && o_cmd_byte[6:3] == ADDR_STATUS_SELECT |->
    o_readback_select == {o_cmd_byte[7], o_cmd_byte[2:0]}; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd");
  property p_echo; o_cmd_valid |-> ##3 o_fault_flags[7] == o_cmd_byte[7];
  endproperty
  a_echo: assert property (p_echo) else $error("echo");
  c_read: cover property (o_cmd_valid && o_readback_select[2:0] == 3'h0);
  c_pin: cover property ($fell(o_fault_status_pin));
  c_latch: cover property ($fell(o_fault_flags[5]));
endmodule : ssrs_status_readback_props
bind ssrs_status_readback ssrs_status_readback_props i_props (
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_cs_n(i_cs_n),
  .i_in_pin(i_in_pin),
  .i_over_temperature(i_over_temperature),
  .i_spi_switch_on(i_spi_switch_on),
  .o_so_oe_n(o_so_oe_n),
  .o_fault_status_pin(o_fault_status_pin),
  .o_fault_flags(o_fault_flags),
  .o_readback_select(o_readback_select),
  .o_cmd_valid(o_cmd_valid),
  .o_cmd_byte(o_cmd_byte)
);

// file: include/ssrs_pkg.sv
package ssrs_pkg;
  localparam int FRAME_BITS = 8;
  localparam int CMD_WD_BIT = 7;
  localparam int CMD_ADDR_LSB = 3;
  localparam logic [3:0] ADDR_STATUS_SELECT = 4'h0;
  localparam int PIN_CS = 3;
  localparam int PIN_IN = 2;
  localparam int PIN_FSI = 1;
  localparam int PIN_WAKE = 0;
  localparam logic [3:0] PIN_RESET = 4'h8;
  localparam logic [3:0] SELECT_RESET = 4'h7;
  localparam logic [7:0] SHADOW_RESET = 8'h70;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  typedef enum logic [2:0] {
    SEL_FAULT = 3'h0,
    SEL_CTRL = 3'h1,
    SEL_OC_LEVEL = 3'h2,
    SEL_OC_TIME = 3'h3,
    SEL_DIRECT = 3'h4,
    SEL_DELAY_WDOG = 3'h5,
    SEL_PINS_VPROT = 3'h6,
    SEL_NULL = 3'h7
  } ssrs_sel_t;
endpackage : ssrs_pkg

// file: src/ssrs_status_readback.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: Select 000 returns the fault word in bits 6 to 0.
// RULE2: Select 001 returns sense-disable bit 1 and commanded switch bit 0.
// RULE3: Select 010 returns high level bit 3, low levels bits 2 to 0.
// RULE4: Fault word order: temp, oc high, oc low, open, uv, ov, summary.
// RULE5: Overcurrent high and low flags stay latched once set.
// RULE6: Undervoltage flag may be latched or follow the live condition.
// RULE7: Summary flag sets on any fault, clears when the word is read.
// RULE8: Fault pin sets on a fault, clears only on a switch-on command.
// RULE9: Select 011 returns the blanking time bits in bits 1 and 0.
// RULE10: Select 011 also returns timeout bit 2 and open load bit 3.
// RULE11: Select 100 returns the direct-input control register.
// RULE12: Select 101 extra 0 returns delay setting, fail-safe state bit 3.
// RULE13: Select 101 extra 1 returns watchdog period and timeout bit 2.
// RULE14: Select 110 extra 0 returns in, fail-safe and wake pin levels.
// RULE15: Select 110 extra 1 returns undervoltage bit 1, overvoltage bit 0.
// RULE16: Select 111 returns zeros in bits 2 to 0.
// RULE17: Bit 7 echoes the previous toggle bit, or the extra select bit.
// RULE18: Status-select command low bits choose readback until next one.
// RULE19: Word leaves MSB first while the new command shifts in.
// RULE20: Only whole-byte frames are latched; output floats after frame.
// RULE21: After reset the selection is the null code.
module ssrs_status_readback (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  input wire logic i_in_pin,
  input wire logic i_failsafe_input_pin,
  input wire logic i_wake_pin,
  input wire logic i_over_temperature,
  input wire logic i_overcurrent_high,
  input wire logic i_overcurrent_low,
  input wire logic i_open_load,
  input wire logic i_undervoltage,
  input wire logic i_overvoltage,
  input wire logic i_uv_latched_mode,
  input wire logic i_spi_switch_on,
  input wire logic i_current_sense_disable_bit,
  input wire logic i_spi_switch_bit,
  input wire logic i_oc_high_level,
  input wire logic [2:0] i_oc_low_level,
  input wire logic [1:0] i_oc_blank_time,
  input wire logic i_oc_timeout_dis,
  input wire logic i_open_load_dis,
  input wire logic [3:0] i_direct_input_control_register,
  input wire logic [2:0] i_switching_delay_register,
  input wire logic i_failsafe_output_state,
  input wire logic [1:0] i_watchdog_period_register,
  input wire logic i_watchdog_timed_out,
  input wire logic i_uv_protect_dis,
  input wire logic i_ov_protect_dis,
  output logic o_fault_status_pin,
  output logic [ssrs_pkg::FRAME_BITS-1:0] o_fault_flags,
  output logic [3:0] o_readback_select,
  output logic o_cmd_valid,
  output logic [ssrs_pkg::FRAME_BITS-1:0] o_cmd_byte
);
  import ssrs_pkg::*;

  // Link side, clocked by the serial clock (idle low, sample on rise).
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic valid;
  logic next_valid;
  logic started;
  logic so_q;
  logic next_so;

  // System side.
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] filt;
  logic [3:0] next_filt;
  logic [3:0] sel;
  logic [3:0] next_sel;
  logic wd_echo;
  logic next_wd_echo;
  logic och;
  logic next_och;
  logic ocl;
  logic next_ocl;
  logic uv_held;
  logic next_uv_held;
  logic summary;
  logic next_summary;
  logic fs;
  logic next_fs;
  logic [7:0] shadow;
  logic [7:0] next_shadow;
  logic [7:0] word;
  logic [7:0] fault_word;
  logic cs_rise;
  logic in_rise;
  logic frame_ok;
  logic is_select;
  logic read_fault;
  logic uv_live;
  logic ov_live;
  logic uv_flag;
  logic any_fault;
  logic switch_on;
  logic cmd_valid;
  logic [7:0] cmd_byte;

  // A new event beats a clear in the same cycle, so no fault is lost to a
  // read that happens to end just as it occurs.
  function automatic logic hold_flag(input logic set, input logic held,
                                     input logic clear);
    return set | (held & ~clear);
  endfunction : hold_flag

  // The counter notes when eight bits have passed; bit 3 stays set after.
  always_comb begin
    next_cnt = {cnt[3] | (&cnt[2:0]), cnt[2:0] + 3'h1};
    next_rx = {rx[6:0], i_si};
    next_valid = &cnt[2:0]; // RULE20
    next_so = cnt[3] ? rx[7] : shadow[3'h7 - cnt[2:0]]; // RULE19
  end

  // The frame's own select clears the link counters, so no edge is needed
  // after the last one of a frame.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt <= COUNT_RESET;
    end else begin
      cnt <= next_cnt;
    end
  end

  // The length flag is not cleared by select, so a frame with no clock at
  // all reuses the previous verdict; masters must not send empty frames.
  always_ff @(posedge i_sclk) begin
    rx <= next_rx;
    valid <= next_valid;
  end

  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      started <= 1'h0;
      so_q <= 1'h0;
    end else begin
      started <= 1'h1;
      so_q <= next_so;
    end
  end

  // Before the first falling edge the MSB of the frozen word is shown.
  assign o_so = started ? so_q : shadow[7]; // RULE19
  assign o_so_oe_n = i_cs_n; // RULE20

  // Pin synchronisers and the filter: a change counts once stages agree.
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < 4; i++) begin
      if (s2[i] == s3[i]) begin
        next_filt[i] = s3[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1 <= PIN_RESET;
      s2 <= PIN_RESET;
      s3 <= PIN_RESET;
      filt <= PIN_RESET;
    end else if (i_ce) begin
      s1 <= {i_cs_n, i_in_pin, i_failsafe_input_pin, i_wake_pin};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // The shift register and length flag are stable while select is high,
  // since the master gives no clock then; that is what makes them safe
  // to read here. Select must stay high a few system cycles.
  always_comb begin
    cs_rise = s2[PIN_CS] & s3[PIN_CS] & ~filt[PIN_CS];
    in_rise = s2[PIN_IN] & s3[PIN_IN] & ~filt[PIN_IN];
    frame_ok = cs_rise & (valid == 1'h1); // RULE20
    is_select = rx[6:CMD_ADDR_LSB] == ADDR_STATUS_SELECT;
    read_fault = frame_ok & (sel[2:0] == SEL_FAULT); // RULE7
    switch_on = i_spi_switch_on | in_rise; // RULE8
    uv_live = i_undervoltage & ~i_uv_protect_dis;
    ov_live = i_overvoltage & ~i_ov_protect_dis;
    any_fault = i_over_temperature | i_overcurrent_high | i_overcurrent_low
      | i_open_load | uv_live | ov_live;
    next_sel = sel;
    if (frame_ok && is_select) begin
      next_sel = {rx[CMD_WD_BIT], rx[2:0]}; // RULE18
    end
    next_wd_echo = frame_ok ? rx[CMD_WD_BIT] : wd_echo; // RULE17
    next_och = hold_flag(i_overcurrent_high, och, read_fault); // RULE5
    next_ocl = hold_flag(i_overcurrent_low, ocl, read_fault); // RULE5
    next_uv_held = hold_flag(uv_live, uv_held, read_fault); // RULE6
    uv_flag = i_uv_latched_mode ? uv_held : uv_live; // RULE6
    next_summary = hold_flag(any_fault, summary, read_fault); // RULE7
    next_fs = hold_flag(any_fault, fs, switch_on); // RULE8
    cmd_valid = frame_ok;
    cmd_byte = frame_ok ? rx : o_cmd_byte;
  end

  always_comb begin
    fault_word = {wd_echo, i_over_temperature, och, ocl, i_open_load,
      uv_flag, ov_live, summary}; // RULE4
    word = {wd_echo, sel[2:0], 4'h0}; // RULE17
    unique case (ssrs_sel_t'(sel[2:0]))
      SEL_FAULT: begin
        word = fault_word; // RULE1
      end
      SEL_CTRL: begin
        word[1:0] = {i_current_sense_disable_bit, i_spi_switch_bit}; // RULE2
      end
      SEL_OC_LEVEL: begin
        word[3:0] = {i_oc_high_level, i_oc_low_level}; // RULE3
      end
      SEL_OC_TIME: begin
        word[3:2] = {i_open_load_dis, i_oc_timeout_dis}; // RULE10
        word[1:0] = i_oc_blank_time; // RULE9
      end
      SEL_DIRECT: begin
        word[3:0] = i_direct_input_control_register; // RULE11
      end
      SEL_DELAY_WDOG: begin
        word[7] = sel[3]; // RULE17
        if (sel[3]) begin
          word[3:0] = {1'h0, i_watchdog_timed_out,
            i_watchdog_period_register}; // RULE13
        end else begin
          word[3:0] = {i_failsafe_output_state,
            i_switching_delay_register}; // RULE12
        end
      end
      SEL_PINS_VPROT: begin
        word[7] = sel[3]; // RULE17
        if (sel[3]) begin
          word[1:0] = {i_uv_protect_dis, i_ov_protect_dis}; // RULE15
        end else begin
          word[2:0] = {filt[PIN_IN], filt[PIN_FSI], filt[PIN_WAKE]}; // RULE14
        end
      end
      SEL_NULL: begin
        word[2:0] = 3'h0; // RULE16
      end
    endcase
    // The word is frozen while select is low so the link reads a steady
    // value; it reflects the state when the frame began.
    next_shadow = filt[PIN_CS] ? word : shadow;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      och <= 1'h0;
      ocl <= 1'h0;
      uv_held <= 1'h0;
      summary <= 1'h0;
      fs <= 1'h0;
    end else if (i_ce) begin
      och <= next_och;
      ocl <= next_ocl;
      uv_held <= next_uv_held;
      summary <= next_summary;
      fs <= next_fs;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sel <= SELECT_RESET; // RULE21
      wd_echo <= 1'h0;
      shadow <= SHADOW_RESET;
    end else if (i_ce) begin
      sel <= next_sel;
      wd_echo <= next_wd_echo;
      shadow <= next_shadow;
    end
  end

  // The flag word is registered once more for the outputs, so it trails
  // the live inputs by a cycle; the serial word does not wait for it.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_cmd_valid <= 1'h0;
      o_cmd_byte <= '0;
      o_fault_flags <= '0;
    end else if (i_ce) begin
      o_cmd_valid <= cmd_valid;
      o_cmd_byte <= cmd_byte;
      o_fault_flags <= fault_word;
    end
  end

  assign o_fault_status_pin = fs;
  assign o_readback_select = sel;
endmodule : ssrs_status_readback
